// *** cabt_base_timer.sv ***
// counter array base timer: counter, reload, source select, control and mode registers
`timescale 1ns/1ps
`default_nettype none
module cabt_base_timer
  import cabt_pkg::*;
#(
  parameter int MODULES = CABT_MODULES
)
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // special function register port
  input  wire logic [7:0]           sfr_addr,
  input  wire logic                 sfr_wr,
  input  wire logic [7:0]           sfr_wdata,
  output logic      [7:0]           sfr_rdata,
  // count sources and processor state
  input  wire logic                 idle_mode,
  input  wire logic                 timer0_ovf,
  input  wire logic                 clock_multiplier_tick,
  input  wire logic                 serial_baud_overflow,
  input  wire logic                 master_clock_divider_tick,
  input  wire logic                 external_count_input,
  // module side
  input  wire logic [MODULES-1:0]   module_event,
  input  wire logic [MODULES-1:0]   module_flag_irq_enable,
  output logic      [15:0]          count_value,
  output logic                      count_overflow,
  output logic      [2:0]           buffer_enable,
  output logic      [MODULES-1:0]   module_flags,
  // interrupt request
  output logic                      array_irq
);
  import cabt_pkg::*;

  // control register has room for six module flags only
  if (MODULES != CABT_MODULES)
  begin : g_bad_modules
    $error("control register holds exactly six module flags");
  end

  logic [7:0]         count_high_byte_q;
  logic [7:0]         count_low_byte_q;
  logic [7:0]         reload_high_byte_q;
  logic [7:0]         reload_low_byte_q;
  logic [7:0]         mode_q;
  logic               run_bit_q;
  logic               overflow_flag_q;
  logic [MODULES-1:0] event_flag_q;
  logic [3:0]         div12_q;
  logic               div2_q;
  logic               ext_fall;
  logic               src_tick;
  logic               count_en;
  logic               wrap;
  logic [2:0]         src_sel;
  logic               wr_ctrl;

  cabt_edge_sync cabt_edge_sync_i
  (
    .clk  (clk),
    .rstn (rstn),
    .pin  (external_count_input),
    .fall (ext_fall)
  );

  // free running prescalers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      div12_q <= 4'h0;
      div2_q  <= 1'b0;
    end
    else
    begin
      div12_q <= (div12_q == 4'(CABT_DIV12 - 1)) ? 4'h0 : div12_q + 4'h1;
      div2_q  <= ~div2_q;
    end
  end

  assign src_sel = mode_q[CABT_MODE_SRC_LO +: 3];

  // increment source mux
  always_comb
  begin
    case (src_sel) // [R4]
      CABT_SRC_DIV12: src_tick = (div12_q == 4'(CABT_DIV12 - 1));
      CABT_SRC_DIV2:  src_tick = div2_q;
      CABT_SRC_T0:    src_tick = timer0_ovf;
      CABT_SRC_EXT:   src_tick = ext_fall; // [R5]
      CABT_SRC_MULT:  src_tick = clock_multiplier_tick;
      CABT_SRC_SYS:   src_tick = 1'b1;
      CABT_SRC_BAUD:  src_tick = serial_baud_overflow;
      CABT_SRC_MCK:   src_tick = master_clock_divider_tick;
      default:        src_tick = 1'b0;
    endcase
  end

  assign count_en = run_bit_q & src_tick & ~(mode_q[CABT_MODE_IDLE] & idle_mode); // [R8] [R6]
  assign wrap     = count_en & (&{count_high_byte_q, count_low_byte_q}); // [R17]
  assign wr_ctrl  = sfr_wr & (sfr_addr == CABT_ADDR_CTRL);

  // counter bytes; a count event beats a same-cycle byte write
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      count_high_byte_q <= CABT_RESET_BYTE;
      count_low_byte_q  <= CABT_RESET_BYTE;
    end
    else if (wrap)
    begin
      count_high_byte_q <= reload_high_byte_q; // [R2]
      count_low_byte_q  <= reload_low_byte_q;
    end
    else if (count_en)
    begin
      {count_high_byte_q, count_low_byte_q} <= {count_high_byte_q, count_low_byte_q} + 16'h0001; // [R1] [R17]
    end
    else if (sfr_wr && sfr_addr == CABT_ADDR_CNT_H)
      count_high_byte_q <= sfr_wdata;
    else if (sfr_wr && sfr_addr == CABT_ADDR_CNT_L)
      count_low_byte_q <= sfr_wdata;
  end

  // reload bytes and mode register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reload_high_byte_q <= CABT_RESET_BYTE;
      reload_low_byte_q  <= CABT_RESET_BYTE;
      mode_q             <= CABT_RESET_BYTE;
    end
    else if (sfr_wr)
    begin
      if (sfr_addr == CABT_ADDR_RLD_H)
        reload_high_byte_q <= sfr_wdata;
      if (sfr_addr == CABT_ADDR_RLD_L)
        reload_low_byte_q <= sfr_wdata;
      if (sfr_addr == CABT_ADDR_MODE)
        mode_q <= sfr_wdata; // [R7] [R11] [R6]
    end
  end

  // run bit is software owned
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      run_bit_q <= 1'b0;
    else if (wr_ctrl)
      run_bit_q <= sfr_wdata[CABT_CTRL_RUN]; // [R8]
  end

  // overflow flag: hardware set wins over a software clear
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      overflow_flag_q <= 1'b0;
    else if (wrap)
      overflow_flag_q <= 1'b1; // [R9]
    else if (wr_ctrl)
      overflow_flag_q <= sfr_wdata[CABT_CTRL_OVF]; // [R10]
  end

  // per-module event flags
  genvar gi;
  generate
    for (gi = 0; gi < MODULES; gi++)
    begin : g_flag
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
          event_flag_q[gi] <= 1'b0;
        else if (module_event[gi])
          event_flag_q[gi] <= 1'b1; // [R12]
        else if (wr_ctrl)
          event_flag_q[gi] <= sfr_wdata[gi]; // [R12]
      end
    end
  endgenerate

  // read mux
  always_comb
  begin
    case (sfr_addr)
      CABT_ADDR_CTRL:  sfr_rdata = {overflow_flag_q, run_bit_q, event_flag_q};
      CABT_ADDR_MODE:  sfr_rdata = mode_q;
      CABT_ADDR_CNT_H: sfr_rdata = count_high_byte_q;
      CABT_ADDR_CNT_L: sfr_rdata = count_low_byte_q;
      CABT_ADDR_RLD_H: sfr_rdata = reload_high_byte_q;
      CABT_ADDR_RLD_L: sfr_rdata = reload_low_byte_q;
      default:         sfr_rdata = 8'h00;
    endcase
  end

  // shared time base; pin muxing and module functions live in the modules
  assign count_value    = {count_high_byte_q, count_low_byte_q}; // [R3] [R16] [R13] [R14]
  assign count_overflow = wrap;
  assign buffer_enable  = mode_q[CABT_MODE_BUFFER_ENABLE_PAIR45:CABT_MODE_BUFFER_ENABLE_PAIR01]; // [R7]
  assign module_flags   = event_flag_q;
  assign array_irq      = (overflow_flag_q & mode_q[CABT_MODE_OVFIE])
                        | (|(event_flag_q & module_flag_irq_enable)); // [R11] [R15]

  reload_load_a: assert property (@(posedge clk) disable iff (!rstn) // [R2]
    wrap |=> count_value == $past({reload_high_byte_q, reload_low_byte_q}))
    else $error("reload not loaded on overflow");
  ovf_set_a: assert property (@(posedge clk) disable iff (!rstn) // [R9]
    wrap |=> overflow_flag_q) else $error("overflow flag not set");
  ovf_hold_a: assert property (@(posedge clk) disable iff (!rstn) // [R10]
    overflow_flag_q && !wr_ctrl |=> overflow_flag_q) else $error("overflow flag lost");
  halt_a: assert property (@(posedge clk) disable iff (!rstn) // [R8]
    !run_bit_q |=> $stable(count_value) || $past(sfr_wr)) else $error("counter moved while halted");
  idle_gate_a: assert property (@(posedge clk) disable iff (!rstn) // [R6]
    mode_q[CABT_MODE_IDLE] && idle_mode && !sfr_wr |=> $stable(count_value))
    else $error("counter moved in gated idle");
  incr_a: assert property (@(posedge clk) disable iff (!rstn) // [R17]
    count_en && !wrap |=> count_value == $past(count_value) + 16'h0001) else $error("bad increment");
  irq_a: assert property (@(posedge clk) disable iff (!rstn) // [R11] [R15]
    array_irq |-> (overflow_flag_q && mode_q[CABT_MODE_OVFIE]) || |(event_flag_q & module_flag_irq_enable))
    else $error("spurious interrupt");
  evt_set_a: assert property (@(posedge clk) disable iff (!rstn) // [R12]
    module_event[0] |=> event_flag_q[0]) else $error("module flag not set");
  sys_src_a: assert property (@(posedge clk) disable iff (!rstn) // [R4]
    src_sel == CABT_SRC_SYS && run_bit_q && !idle_mode |-> count_en) else $error("system source not counting");

  wrap_c: cover property (@(posedge clk) disable iff (!rstn) wrap);
  ext_c: cover property (@(posedge clk) disable iff (!rstn) src_sel == CABT_SRC_EXT && count_en);
  irq_c: cover property (@(posedge clk) disable iff (!rstn) $rose(array_irq));
endmodule : cabt_base_timer
`default_nettype wire

// *** cabt_pkg.sv ***
// constants for the counter array base timer
// Contract
// [R1] one 16-bit counter made of high and low bytes, auto-reloading
// [R2] every 16-bit overflow loads reload bytes into the counter bytes
// [R3] the 16-bit count is the shared time base for six modules
// [R4] three-bit count source field selects one of eight increment sources
// [R5] external source counts once per falling edge of the external pin
// [R6] idle gate set stops counting in idle; clear keeps counting
// [R7] three buffer enable bits cover module pairs 0/1, 2/3, 4/5
// [R8] software sets run bit to count; clearing it halts the counter
// [R9] overflow flag in control bit 7 sets on every rollover
// [R10] hardware never clears overflow flag; software writes clear or set it
// [R11] interrupt from overflow flag only while overflow enable bit 0 is set
// [R12] module event flags set on match or capture; only software clears
// [R13] module event pin stays general purpose I/O when module unused
// [R14] each module configurable as capture, timer, fast output or PWM
// [R15] module flag raises interrupt only with its own enable set
// [R16] valid capture copies counter bytes into module capture pair
// [R17] counter increments by one per event, overflows from all ones
// [R18] external pin synchronised and falling edges detected before use
package cabt_pkg;
  localparam logic [7:0] CABT_ADDR_CTRL   = 8'hD8;
  localparam logic [7:0] CABT_ADDR_MODE   = 8'hD9;
  localparam logic [7:0] CABT_ADDR_CNT_H  = 8'hF9;
  localparam logic [7:0] CABT_ADDR_CNT_L  = 8'hE9;
  localparam logic [7:0] CABT_ADDR_RLD_H  = 8'hCF;
  localparam logic [7:0] CABT_ADDR_RLD_L  = 8'hCE;
  localparam int         CABT_CTRL_OVF    = 7;
  localparam int         CABT_CTRL_RUN    = 6;
  localparam int         CABT_MODE_IDLE   = 7;
  localparam int         CABT_MODE_BUFFER_ENABLE_PAIR45   = 6;
  localparam int         CABT_MODE_BUFFER_ENABLE_PAIR23   = 5;
  localparam int         CABT_MODE_BUFFER_ENABLE_PAIR01   = 4;
  localparam int         CABT_MODE_SRC_LO = 1;
  localparam int         CABT_MODE_OVFIE  = 0;
  localparam logic [7:0] CABT_RESET_BYTE  = 8'h00;
  localparam int         CABT_MODULES     = 6;
  localparam int         CABT_DIV12       = 12;
  localparam int         CABT_DIV2        = 2;
  localparam logic [2:0] CABT_SRC_DIV12   = 3'h0;
  localparam logic [2:0] CABT_SRC_DIV2    = 3'h1;
  localparam logic [2:0] CABT_SRC_T0      = 3'h2;
  localparam logic [2:0] CABT_SRC_EXT     = 3'h3;
  localparam logic [2:0] CABT_SRC_MULT    = 3'h4;
  localparam logic [2:0] CABT_SRC_SYS     = 3'h5;
  localparam logic [2:0] CABT_SRC_BAUD    = 3'h6;
  localparam logic [2:0] CABT_SRC_MCK     = 3'h7;
endpackage : cabt_pkg

// *** cabt_edge_sync.sv ***
// two-flop synchroniser with falling edge pulse for the external count pin
`timescale 1ns/1ps
`default_nettype none
module cabt_edge_sync
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // pin and event
  input  wire logic pin,
  output logic      fall
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  // meta_q feeds only sync_q
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end
    else
    begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign fall = last_q & ~sync_q; // [R18] [R5]

  fall_pulse_a: assert property (@(posedge clk) disable iff (!rstn) // [R18]
    fall |=> !fall) else $error("falling edge pulse longer than a cycle");
endmodule : cabt_edge_sync
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the counter array base timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
  $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module testbench;
  import cabt_pkg::*;
  logic             clk;
  logic             rstn;
  logic [7:0]       addr;
  logic             wr;
  logic [7:0]       wdata;
  wire logic [7:0]  rdata;
  logic             idle;
  logic [3:0]       pulse;
  logic             ext_pin;
  logic [5:0]       mev;
  logic [5:0]       mien;
  wire logic [15:0] cnt;
  wire logic        ovf;
  wire logic [2:0]  bme;
  wire logic [5:0]  mflags;
  wire logic        irq;
  int               num_errors;
  int               checks_done;
  logic [15:0]      c0;
  logic [7:0]       regs [7] = '{CABT_ADDR_CTRL, CABT_ADDR_MODE, CABT_ADDR_CNT_H, CABT_ADDR_CNT_L,
                                 CABT_ADDR_RLD_H, CABT_ADDR_RLD_L, 8'hD0};
  logic [2:0]       srcs [4] = '{CABT_SRC_T0, CABT_SRC_MULT, CABT_SRC_BAUD, CABT_SRC_MCK};

  cabt_base_timer cabt_base_timer_i (
    .clk(clk), .rstn(rstn), .sfr_addr(addr), .sfr_wr(wr), .sfr_wdata(wdata), .sfr_rdata(rdata),
    .idle_mode(idle), .timer0_ovf(pulse[0]), .clock_multiplier_tick(pulse[1]),
    .serial_baud_overflow(pulse[2]), .master_clock_divider_tick(pulse[3]),
    .external_count_input(ext_pin), .module_event(mev), .module_flag_irq_enable(mien),
    .count_value(cnt), .count_overflow(ovf), .buffer_enable(bme), .module_flags(mflags), .array_irq(irq)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // an idle edge after each write keeps the strobe from being set twice in one step
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    #1;
    `CHK("sfr_rdata", e, rdata)
  endtask : rd_chk

  task automatic delta(input int n, input logic [15:0] e);
    c0 = cnt;
    tick(n);
    `CHK("count_value step", e, cnt - c0)
  endtask : delta

  task automatic pulse_in(input logic [3:0] p);
    pulse = p;
    tick(1);
    pulse = 4'h0;
    tick(1);
  endtask : pulse_in

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    #200000;
    num_errors++;
    tally_and_finish();
  end

  initial
  begin
    rstn = 1'b0; addr = 8'h00; wr = 1'b0; wdata = 8'h00; idle = 1'b0;
    pulse = 4'h0; ext_pin = 1'b1; mev = 6'h00; mien = 6'h00;
    num_errors = 0; checks_done = 0;
    tick(5);
    rstn = 1'b1;
    tick(1);
    for (int i = 0; i < 7; i++) rd_chk(regs[i], 8'h00);
    wr_reg(8'hD0, 8'hFF);
    rd_chk(8'hD0, 8'h00);
    wr_reg(CABT_ADDR_MODE, 8'h70);
    rd_chk(CABT_ADDR_MODE, 8'h70);
    `CHK("buffer_enable", 3'h7, bme)
    wr_reg(CABT_ADDR_MODE, 8'h50);
    `CHK("buffer_enable", 3'h5, bme)
    $display("test registers done");
    // pulse sources: only the selected one may advance the count
    wr_reg(CABT_ADDR_CTRL, 8'h40);
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(CABT_ADDR_MODE, {4'h0, srcs[i], 1'b0});
      wr_reg(CABT_ADDR_CNT_H, 8'h00);
      wr_reg(CABT_ADDR_CNT_L, 8'h00);
      pulse_in(~(4'h1 << i));
      pulse_in(4'h1 << i);
      `CHK("count_value", 16'h0001, cnt)
    end
    $display("test pulse sources done");
    wr_reg(CABT_ADDR_MODE, {4'h0, CABT_SRC_T0, 1'b1});
    wr_reg(CABT_ADDR_RLD_H, 8'h12);
    wr_reg(CABT_ADDR_RLD_L, 8'h34);
    rd_chk(CABT_ADDR_RLD_H, 8'h12);
    rd_chk(CABT_ADDR_RLD_L, 8'h34);
    wr_reg(CABT_ADDR_CNT_H, 8'hFF);
    wr_reg(CABT_ADDR_CNT_L, 8'hFF);
    pulse = 4'h1;
    #1;
    `CHK("count_overflow", 1'b1, ovf)
    tick(1);
    pulse = 4'h0;
    `CHK("count_value", 16'h1234, cnt)
    rd_chk(CABT_ADDR_CTRL, 8'hC0);
    `CHK("array_irq", 1'b1, irq)
    pulse_in(4'h1);
    pulse_in(4'h1);
    `CHK("count_value", 16'h1236, cnt)
    rd_chk(CABT_ADDR_CNT_H, 8'h12);
    rd_chk(CABT_ADDR_CNT_L, 8'h36);
    rd_chk(CABT_ADDR_CTRL, 8'hC0);
    wr_reg(CABT_ADDR_MODE, {4'h0, CABT_SRC_T0, 1'b0});
    `CHK("array_irq", 1'b0, irq)
    wr_reg(CABT_ADDR_CTRL, 8'h40);
    rd_chk(CABT_ADDR_CTRL, 8'h40);
    wr_reg(CABT_ADDR_CTRL, 8'hC0);
    rd_chk(CABT_ADDR_CTRL, 8'hC0);
    wr_reg(CABT_ADDR_CTRL, 8'h40);
    $display("test overflow done");
    mev = 6'h24;
    tick(1);
    mev = 6'h00;
    `CHK("module_flags", 6'h24, mflags)
    `CHK("array_irq", 1'b0, irq)
    mien = 6'h04;
    #1;
    `CHK("array_irq", 1'b1, irq)
    mien = 6'h01;
    #1;
    `CHK("array_irq", 1'b0, irq)
    wr_reg(CABT_ADDR_CTRL, 8'h40);
    rd_chk(CABT_ADDR_CTRL, 8'h40);
    $display("test module flags done");
    // clock derived sources, idle gate and run bit
    wr_reg(CABT_ADDR_MODE, 8'h0A);
    delta(10, 16'd10);
    wr_reg(CABT_ADDR_MODE, 8'h02);
    delta(10, 16'd5);
    wr_reg(CABT_ADDR_MODE, 8'h00);
    delta(24, 16'd2);
    idle = 1'b1;
    wr_reg(CABT_ADDR_MODE, 8'h8A);
    delta(10, 16'd0);
    wr_reg(CABT_ADDR_MODE, 8'h0A);
    delta(10, 16'd10);
    idle = 1'b0;
    wr_reg(CABT_ADDR_CTRL, 8'h00);
    delta(10, 16'd0);
    $display("test clock sources done");
    wr_reg(CABT_ADDR_MODE, 8'h06);
    wr_reg(CABT_ADDR_CTRL, 8'h40);
    c0 = cnt;
    ext_pin = 1'b0;
    tick(5);
    `CHK("count_value", c0 + 16'h0001, cnt)
    ext_pin = 1'b1;
    tick(5);
    `CHK("count_value", c0 + 16'h0001, cnt)
    $display("test external pin done");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
